// [drive_protection_supervisor.sv]
module drive_protection_supervisor #(
	parameter int TENTH_CYCLES = dps_pkg::TENTH_CYC
) (
	// Clock and reset
	input  wire logic               mclk_in,
	input  wire logic               rst_in,
	// Measurement and ramp
	input  wire logic               tick_in,
	input  wire logic [8:0]         current_in,
	input  wire logic [15:0]        cmd_freq_in,
	input  wire logic [15:0]        accel_step_in,
	input  wire logic [15:0]        decel_step_in,
	input  wire logic               bus_high_in,
	input  wire logic               low_speed_in,
	// User limits
	input  wire logic [8:0]         accel_stall_limit_in,
	input  wire logic [8:0]         run_stall_limit_in,
	input  wire logic [8:0]         torque_trip_level_in,
	input  wire logic [9:0]         torque_trip_time_in,
	input  wire dps_pkg::tq_mode_t  torque_mode_in,
	input  wire dps_pkg::th_mode_t  thermal_mode_in,
	input  wire logic [9:0]         thermal_time_in,
	// Fault sources and operator reset
	input  wire dps_pkg::fault_src_t faults_in,
	input  wire logic               fault_reset_in,
	// Outputs
	output logic [15:0]             freq_out,
	output logic                    stall_out,
	output logic                    over_torque_detect_out,
	output logic                    halt_out,
	output logic                    fault_out,
	output dps_pkg::hist_t          fault_hist_out
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [9:0] clamp(input logic [9:0] v, input logic [9:0] lo, input logic [9:0] hi);
		clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction : clamp

	function automatic logic [15:0] sat_sub(input logic [15:0] a, input logic [15:0] b,
		input logic [15:0] floor);
		sat_sub = ({1'b0, a} > {1'b0, floor} + {1'b0, b} && a >= b) ? a - b : floor;
	endfunction : sat_sub

	dps_pkg::sup_t st;
	dps_pkg::sup_t next_st;

	// ----------------------------------------
	// Clamped settings
	// ----------------------------------------
	logic [8:0]  acc_lim;
	logic [8:0]  run_lim;
	logic [8:0]  tq_lvl;
	logic [9:0]  tq_time;
	logic [13:0] th_thr;
	logic        accel_ph;
	logic        decel_ph;
	logic        dbl;
	logic [16:0] up_sum;
	logic        tenth;
	logic [16:1] act;
	logic        any_fault;
	logic [4:0]  code;
	logic        steady_only;

	// Currents in percent of rated current; tq_time and th_thr in tenths of a second
	assign acc_lim  = 9'(clamp({1'b0, accel_stall_limit_in}, {1'b0, dps_pkg::STALL_MIN},
		{1'b0, dps_pkg::STALL_MAX}));
	assign run_lim  = 9'(clamp({1'b0, run_stall_limit_in}, {1'b0, dps_pkg::STALL_MIN},
		{1'b0, dps_pkg::STALL_MAX}));
	assign tq_lvl   = (torque_trip_level_in > dps_pkg::TQ_MAX) ? dps_pkg::TQ_MAX : torque_trip_level_in;
	assign tq_time  = clamp(torque_trip_time_in, dps_pkg::TQ_T_MIN, dps_pkg::TQ_T_MAX);
	assign th_thr   = 14'(clamp(thermal_time_in, dps_pkg::TH_T_MIN, dps_pkg::TH_T_MAX))
		* 14'(dps_pkg::TENTHS_S);
	assign accel_ph = st.freq < cmd_freq_in;
	assign decel_ph = st.freq > cmd_freq_in;
	assign dbl      = tick_in && (current_in > dps_pkg::PCT_DOUBLE) && st.freq != 16'h0000;
	assign up_sum   = {1'b0, st.freq} + {1'b0, accel_step_in};
	assign tenth    = st.pre == 24'(TENTH_CYCLES - 1);
	assign steady_only = torque_mode_in == dps_pkg::TQ_STDY_RUN || torque_mode_in == dps_pkg::TQ_STDY_HALT;

	// ----------------------------------------
	// Fault coding
	// ----------------------------------------
	always_comb begin
		act = {faults_in[12:9], 3'h0, faults_in[8:0]};
		act[dps_pkg::FC_THERM] = faults_in.motor_thermal_overload_fault
			|| (thermal_mode_in != dps_pkg::TH_OFF && st.th_acc >= th_thr);
		act[dps_pkg::FC_DBL_AC] = dbl && accel_ph;
		act[dps_pkg::FC_DBL_DE] = dbl && decel_ph;
		act[dps_pkg::FC_DBL_ST] = dbl && !accel_ph && !decel_ph;
		any_fault = |act;
		code = 5'h00;
		for (int i = 16; i >= 1; i--) begin
			if (act[i]) begin
				code = 5'(i);
			end
		end
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_st = st;
		next_st.pre = tenth ? 24'h000000 : st.pre + 24'h000001;
		// Frequency path moves only on a tick, except the forced zero in fault or torque halt
		if (st.state == dps_pkg::ST_FAULT || st.tq_halt) begin
			next_st.freq = 16'h0000;
			next_st.recover = 1'b0;
			next_st.stall = 1'b0;
		end else if (tick_in) begin
			next_st.stall = 1'b0;
			if (!accel_ph && !decel_ph) begin
				next_st.recover = 1'b0;
				if (current_in > run_lim) begin
					next_st.freq = sat_sub(st.freq, accel_step_in, 16'h0000);
					next_st.recover = 1'b1;
					next_st.stall = 1'b1;
				end
			end else if (accel_ph) begin
				if (st.recover && current_in > run_lim) begin
					next_st.freq = sat_sub(st.freq, accel_step_in, 16'h0000);
					next_st.stall = 1'b1;
				end else if (!st.recover && current_in > acc_lim) begin
					next_st.stall = 1'b1;
				end else begin
					// Recovery and normal accel share the ramp
					next_st.freq = (up_sum > {1'b0, cmd_freq_in}) ? cmd_freq_in : up_sum[15:0];
				end
			end else begin
				next_st.recover = 1'b0;
				// Regeneration holds frequency, stretching decel
				if (bus_high_in) begin
					next_st.stall = 1'b1;
				end else begin
					next_st.freq = sat_sub(st.freq, decel_step_in, cmd_freq_in);
				end
			end
		end

		// Over-torque qualifier counts in tenths of a second
		if (st.tq_over && tenth && st.tq_cnt != dps_pkg::TQ_T_MAX) begin
			next_st.tq_cnt = st.tq_cnt + 10'h001;
		end
		// Restart or disable wins over a coinciding count step
		if (torque_mode_in == dps_pkg::TQ_OFF) begin
			next_st.tq_over = 1'b0;
			next_st.tq_cnt = 10'h000;
		end else if (tick_in) begin
			next_st.tq_over = current_in > tq_lvl && !(steady_only && (accel_ph || decel_ph));
			if (!next_st.tq_over) begin
				next_st.tq_cnt = 10'h000;
			end
		end
		next_st.ot = torque_mode_in != dps_pkg::TQ_OFF && st.tq_cnt >= tq_time;
		if (st.ot && (torque_mode_in == dps_pkg::TQ_STDY_HALT || torque_mode_in == dps_pkg::TQ_ANY_HALT)) begin
			next_st.tq_halt = 1'b1;
		end else if (fault_reset_in && !st.tq_over) begin
			next_st.tq_halt = 1'b0;
		end

		// Thermal accumulation; standard motor heats faster at low speed
		if (thermal_mode_in == dps_pkg::TH_OFF) begin
			next_st.th_acc = 14'h0000;
		end else if (tenth) begin
			if (current_in > dps_pkg::PCT_RATED) begin
				if (st.th_acc < th_thr) begin
					next_st.th_acc = st.th_acc + ((thermal_mode_in == dps_pkg::TH_STD && low_speed_in)
						? 14'h0002 : 14'h0001);
				end
			end else if (st.th_acc != 14'h0000) begin
				next_st.th_acc = st.th_acc - 14'h0001;
			end
		end

		// First fault is logged; later ones are not logged, and any still active blocks the reset
		unique case (st.state)
			dps_pkg::ST_RUN: begin
				if (any_fault) begin
					next_st.hist = {st.hist[2:0], {3'h0, code}};
					next_st.state = dps_pkg::ST_FAULT;
				end
			end
			dps_pkg::ST_FAULT: begin
				if (fault_reset_in && !any_fault) begin
					next_st.state = dps_pkg::ST_RUN;
					next_st.th_acc = 14'h0000;
				end
			end
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			st <= '0;
			st.state <= dps_pkg::ST_RUN;
			st.hist <= {4{dps_pkg::FC_NONE}};
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign freq_out               = st.freq;
	assign stall_out              = st.stall;
	assign over_torque_detect_out = st.ot;
	assign halt_out               = st.tq_halt || st.state == dps_pkg::ST_FAULT;
	assign fault_out              = st.state == dps_pkg::ST_FAULT;
	assign fault_hist_out         = st.hist;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (rst_in);

	logic ok;
	assign ok = !halt_out && !any_fault;

	a_accel_hold_freq: assert property (ok && tick_in && accel_ph && !st.recover && current_in > acc_lim
		|=> freq_out == $past(freq_out) && stall_out)
		else $error("accel stall did not hold frequency");
	a_run_stall_drop: assert property (ok && tick_in && !accel_ph && !decel_ph && current_in > run_lim
		&& freq_out != 16'h0000 && accel_step_in != 16'h0000 |=> freq_out < $past(freq_out))
		else $error("run stall did not lower frequency");
	a_recover_ramp_up: assert property (ok && tick_in && st.recover && accel_ph && current_in <= run_lim
		&& accel_step_in != 16'h0000 |=> freq_out > $past(freq_out))
		else $error("no recovery toward command");
	a_decel_regen_hold: assert property (ok && tick_in && decel_ph && bus_high_in
		|=> freq_out == $past(freq_out))
		else $error("decel not stretched");
	a_tq_mode_off: assert property (torque_mode_in == dps_pkg::TQ_OFF [*2] |-> !over_torque_detect_out)
		else $error("over-torque reported while disabled");
	a_tq_halt_mode: assert property (over_torque_detect_out && torque_mode_in == dps_pkg::TQ_ANY_HALT
		|=> halt_out)
		else $error("halt mode kept running");
	a_tq_restart: assert property (tick_in && torque_mode_in != dps_pkg::TQ_OFF && current_in <= tq_lvl
		|=> st.tq_cnt == 10'h000 ##1 !over_torque_detect_out)
		else $error("torque timer not restarted");
	a_hist_shift: assert property (!fault_out && any_fault |=> fault_out
		&& fault_hist_out[1] == $past(fault_hist_out[0]) && fault_hist_out[3] == $past(fault_hist_out[2]))
		else $error("history not shifted");
	a_dbl_accel_code: assert property (!fault_out && dbl && accel_ph && act[9:1] == 9'h000
		|=> fault_hist_out[0] == {3'h0, dps_pkg::FC_DBL_AC})
		else $error("wrong double-current code");
	a_fault_leave: assert property (fault_out && fault_reset_in && !any_fault |=> !fault_out)
		else $error("fault state not left");

	c_accel_stall: cover property (tick_in && accel_ph && current_in > acc_lim ##1 stall_out);
	c_tq_detect: cover property (!over_torque_detect_out ##1 over_torque_detect_out);
	c_fault_reset: cover property (fault_out ##1 !fault_out);
endmodule : drive_protection_supervisor

// [dps_pkg.sv]
package dps_pkg;
	// ----------------------------------------
	// Limits and timing
	// ----------------------------------------
	localparam logic [8:0] PCT_RATED  = 9'h064;
	localparam logic [8:0] PCT_DOUBLE = 9'h0C8;
	localparam logic [8:0] STALL_MIN  = 9'h014;
	localparam logic [8:0] STALL_MAX  = 9'h0FA;
	localparam logic [8:0] TQ_MAX     = 9'h0C8;
	localparam logic [9:0] TQ_T_MIN   = 10'h001;
	localparam logic [9:0] TQ_T_MAX   = 10'h258;
	localparam logic [9:0] TH_T_MIN   = 10'h01E;
	localparam logic [9:0] TH_T_MAX   = 10'h258;
	localparam logic [3:0] TENTHS_S   = 4'hA;
	localparam int TENTH_NS  = 100000000;
	localparam int CLK_NS    = 100;
	localparam int TENTH_CYC = TENTH_NS / CLK_NS;
	// ----------------------------------------
	// Modes and fault codes
	// ----------------------------------------
	typedef enum logic [2:0] {TQ_OFF = 3'h0, TQ_STDY_RUN = 3'h1, TQ_STDY_HALT = 3'h2,
		TQ_ANY_RUN = 3'h3, TQ_ANY_HALT = 3'h4} tq_mode_t;
	typedef enum logic [1:0] {TH_STD = 2'h0, TH_SPECIAL = 2'h1, TH_OFF = 2'h2} th_mode_t;
	localparam logic [7:0] FC_NONE   = 8'h00;
	localparam logic [4:0] FC_THERM  = 5'h05;
	localparam logic [4:0] FC_DBL_AC = 5'h0A;
	localparam logic [4:0] FC_DBL_DE = 5'h0B;
	localparam logic [4:0] FC_DBL_ST = 5'h0C;
	// Bits 0..8 carry codes 1..9, bits 9..12 carry codes 13..16; codes 10..12 come from inside
	typedef struct packed {
		logic processor_write_fault;
		logic processor_read_fault;
		logic low_voltage_fault;
		logic ground_fault;
		logic hardware_protection_fault;
		logic processor_failure_fault;
		logic transistor_fault;
		logic external_fault;
		logic motor_thermal_overload_fault;
		logic drive_overload_fault;
		logic overheat_fault;
		logic over_voltage_fault;
		logic over_current_fault;
	} fault_src_t;
	typedef logic [3:0][7:0] hist_t;
	typedef enum logic [0:0] {ST_RUN, ST_FAULT} sup_state_t;
	typedef struct packed {
		sup_state_t  state;
		logic [15:0] freq;
		logic        recover;
		logic        stall;
		logic [23:0] pre;
		logic [9:0]  tq_cnt;
		logic        tq_over;
		logic        ot;
		logic        tq_halt;
		logic [13:0] th_acc;
		hist_t       hist;
	} sup_t;
endpackage : dps_pkg

// [load_model.sv]
module load_model (
	// Clock and reset
	input  wire logic       mclk_in,
	input  wire logic       rst_in,
	// Load demand from the bench
	input  wire logic [8:0] load_pct_in,
	// Sensed current and control tick
	output logic            tick_out,
	output logic [8:0]      current_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] div;
	// ----------------------------------------
	// Sensing and tick
	// ----------------------------------------
	// One cycle of sensing lag, so a load change lands before the next tick
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			div         <= 2'h0;
			tick_out    <= 1'b0;
			current_out <= 9'h000;
		end else begin
			div         <= div + 2'h1;
			tick_out    <= (div == 2'h2);
			current_out <= load_pct_in;
		end
	end
endmodule : load_model

// [test_drive_protection_supervisor.sv]
module test_drive_protection_supervisor;
	timeunit 1ns;
	timeprecision 1ns;
	logic                mclk_in, rst_in, tick_in, bus_high_in, low_speed_in, fault_reset_in;
	logic [8:0]          current_in, load, accel_stall_limit_in, run_stall_limit_in, torque_trip_level_in;
	logic [15:0]         cmd_freq_in, accel_step_in, decel_step_in, freq_out;
	logic [9:0]          torque_trip_time_in, thermal_time_in;
	dps_pkg::tq_mode_t   torque_mode_in;
	dps_pkg::th_mode_t   thermal_mode_in;
	dps_pkg::fault_src_t faults_in;
	logic                stall_out, over_torque_detect_out, halt_out, fault_out;
	dps_pkg::hist_t      fault_hist_out;
	int                  n_mismatch, checks_done, cyc, k;
	logic [7:0]          codes [13] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
		8'h0D, 8'h0E, 8'h0F, 8'h10};
	logic [7:0]          prev;
	drive_protection_supervisor #(.TENTH_CYCLES(10)) dut (.mclk_in, .rst_in, .tick_in, .current_in,
		.cmd_freq_in, .accel_step_in, .decel_step_in, .bus_high_in, .low_speed_in, .accel_stall_limit_in,
		.run_stall_limit_in, .torque_trip_level_in, .torque_trip_time_in, .torque_mode_in, .thermal_mode_in,
		.thermal_time_in, .faults_in, .fault_reset_in, .freq_out, .stall_out, .over_torque_detect_out,
		.halt_out, .fault_out, .fault_hist_out);
	load_model far (.mclk_in, .rst_in, .load_pct_in(load), .tick_out(tick_in), .current_out(current_in));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task conclude;
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : conclude
	task cyc1;
		@(posedge mclk_in);
		#1;
	endtask : cyc1
	task ticks(input int n);
		repeat (n) @(posedge mclk_in iff tick_in);
		#1;
	endtask : ticks
	task setl(input logic [8:0] v);
		@(posedge mclk_in) load <= v;
	endtask : setl
	// Operator reset only once the cause has gone away
	task op_reset;
		@(posedge mclk_in) fault_reset_in <= 1'b1;
		@(posedge mclk_in) fault_reset_in <= 1'b0;
		repeat (2) cyc1();
	endtask : op_reset
	task wait_detect;
		for (k = 0; k < 80 && over_torque_detect_out !== 1'b1; k++) cyc1();
	endtask : wait_detect
	initial begin
		mclk_in = 1'b0;
		forever #50 mclk_in = ~mclk_in;
	end
	always @(posedge mclk_in) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			n_mismatch++;
			conclude();
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{rst_in, bus_high_in, low_speed_in, fault_reset_in} = 4'h8;
		{load, cmd_freq_in, accel_step_in, decel_step_in} = '0;
		{accel_stall_limit_in, run_stall_limit_in, torque_trip_level_in} = {9'h0AA, 9'h0AA, 9'h096};
		{torque_trip_time_in, thermal_time_in} = {10'h003, 10'h01E};
		torque_mode_in = dps_pkg::TQ_OFF;
		thermal_mode_in = dps_pkg::TH_OFF;
		faults_in = '0;
		{n_mismatch, checks_done, cyc} = '0;
		prev = 8'h00;
		repeat (20) cyc1();
		chk({freq_out, stall_out, over_torque_detect_out, halt_out, fault_out}, 32'h0);
		chk(fault_hist_out, 32'h0);
		@(posedge mclk_in) rst_in <= 1'b0;
		for (int i = 0; i < 13; i++) begin
			@(posedge mclk_in) faults_in <= dps_pkg::fault_src_t'(13'h1 << i);
			@(posedge mclk_in) faults_in <= '0;
			repeat (2) cyc1();
			chk({fault_out, halt_out}, 2'h3);
			chk(fault_hist_out[0], codes[i]);
			chk(fault_hist_out[1], prev);
			prev = codes[i];
			op_reset();
			chk(fault_out, 1'b0);
		end
		chk(fault_hist_out, 32'h0D0E0F10);
		@(posedge mclk_in) {cmd_freq_in, accel_step_in, load} <= {16'h0100, 16'h0010, 9'h032};
		ticks(4);
		chk(freq_out, 16'h0040);
		setl(9'h0B4);
		ticks(2);
		chk({freq_out, stall_out}, {16'h0040, 1'b1});
		setl(9'h032);
		ticks(14);
		chk(freq_out, 16'h0100);
		setl(9'h0B4);
		ticks(2);
		chk({freq_out, stall_out}, {16'h00E0, 1'b1});
		setl(9'h032);
		ticks(2);
		chk({freq_out, stall_out}, {16'h0100, 1'b0});
		setl(9'h0D2);
		ticks(2);
		repeat (2) cyc1();
		chk({fault_out, fault_hist_out[0]}, {1'b1, 8'h0C});
		chk(freq_out, 16'h0);
		setl(9'h032);
		op_reset();
		ticks(2);
		setl(9'h0D2);
		ticks(1);
		chk({fault_out, fault_hist_out[1:0]}, {1'b1, 8'h0C, 8'h0A});
		setl(9'h032);
		op_reset();
		ticks(18);
		@(posedge mclk_in) {cmd_freq_in, decel_step_in, bus_high_in} <= {16'h0000, 16'h0020, 1'b1};
		ticks(2);
		chk({freq_out, stall_out}, {16'h0100, 1'b1});
		@(posedge mclk_in) bus_high_in <= 1'b0;
		ticks(2);
		chk(freq_out, 16'h00C0);
		setl(9'h0D2);
		ticks(1);
		chk({fault_out, fault_hist_out[1:0]}, {1'b1, 8'h0A, 8'h0B});
		setl(9'h032);
		op_reset();
		@(posedge mclk_in) {cmd_freq_in, torque_mode_in, load} <= {16'h0100, dps_pkg::TQ_ANY_RUN, 9'h0A0};
		ticks(3);
		setl(9'h064);
		ticks(2);
		setl(9'h0A0);
		ticks(3);
		chk(over_torque_detect_out, 1'b0);
		wait_detect();
		chk({over_torque_detect_out, halt_out}, 2'h2);
		setl(9'h064);
		ticks(3);
		@(posedge mclk_in) {torque_mode_in, load} <= {dps_pkg::TQ_ANY_HALT, 9'h0A0};
		wait_detect();
		repeat (2) cyc1();
		chk({halt_out, freq_out}, {1'b1, 16'h0});
		setl(9'h064);
		// Detection must drop before the operator reset can clear the halt
		ticks(3);
		op_reset();
		chk(halt_out, 1'b0);
		@(posedge mclk_in) {torque_mode_in, load} <= {dps_pkg::TQ_OFF, 9'h0A0};
		repeat (80) cyc1();
		chk(over_torque_detect_out, 1'b0);
		@(posedge mclk_in) {thermal_mode_in, load} <= {dps_pkg::TH_SPECIAL, 9'h078};
		repeat (2800) cyc1();
		chk(fault_out, 1'b0);
		for (k = 0; k < 500 && fault_out !== 1'b1; k++) cyc1();
		chk({fault_out, fault_hist_out[0]}, {1'b1, 8'h05});
		@(posedge mclk_in) rst_in <= 1'b1;
		repeat (2) cyc1();
		chk(fault_hist_out, 32'h0);
		chk({fault_out, halt_out, freq_out}, 18'h0);
		conclude();
	end
endmodule : test_drive_protection_supervisor
